// ---- verilog/ccss_consts.svh ----
`ifndef CCSS_CONSTS_SVH
`define CCSS_CONSTS_SVH

`define CCSS_CLK_MHZ        100
`define CCSS_RAMP_MS        470
`define CCSS_CAL_MS         4
`define CCSS_RAMP_CYC       (`CCSS_RAMP_MS * 1000 * `CCSS_CLK_MHZ)
`define CCSS_CAL_CYC        (`CCSS_CAL_MS * 1000 * `CCSS_CLK_MHZ)
`define CCSS_START_FRAMES   6

`define CCSS_IDX_STAT       0
`define CCSS_IDX_ADCSEL     2
`define CCSS_IDX_GAIN_LO    3
`define CCSS_IDX_GAIN_HI    10
`define CCSS_IDX_MIX_A      13
`define CCSS_IDX_MIX_B      14
`define CCSS_IDX_CLKSEL     15
`define CCSS_IDX_CG_LO      16
`define CCSS_IDX_CG_HI      24
`define CCSS_IDX_FILT       25
`define CCSS_IDX_SER        26
`define CCSS_IDX_ENA        27
`define CCSS_IDX_PWR        28
`define CCSS_IDX_LAST       28

`define CCSS_STAT_INIT      15
`define CCSS_STAT_PDS       14

`define CCSS_ENA_DAC1       8
`define CCSS_ENA_DAC2       9
`define CCSS_ENA_ADCL       0
`define CCSS_ENA_ADCR       1
`define CCSS_ENA_DDMIX      12
`define CCSS_ENA_AAMIX      4

`define CCSS_PWR_PDREQ      15
`define CCSS_PWR_AUTOCAL_FORCE_ENABLE       14
`define CCSS_PWR_CG_LSB     11
`define CCSS_SER_LOCK       4

`define CCSS_SEL_DAC1       8
`define CCSS_SEL_DAC2       10
`define CCSS_SEL_ADCL       0
`define CCSS_SEL_ADCR       2

`define CCSS_PWR_RST        16'h8000
`define CCSS_GAIN_RST       16'h8080
`define CCSS_CFG_RST        16'h0000

`endif

// ---- verilog/ccss_pkg.sv ----
`include "ccss_consts.svh"

package ccss_pkg;

    typedef enum logic [1:0] {PWR_DOWN, PWR_RAMP, PWR_CAL, PWR_STBY} ccss_pwr_t;

    typedef enum logic [1:0] {RS_OFF, RS_COUNT, RS_WAIT, RS_RUN} ccss_rs_t;

    typedef struct packed {
        logic [2:0] clkgen_en;
        logic [2:0] conv_out_en;
        logic [2:0] bit_out_en;
    } ccss_clkout_t;

    typedef struct packed {
        logic [1:0] dac_run;
        logic [1:0] adc_sample;
        logic       dac2_mix;
        logic       adc_mix;
    } ccss_conv_t;

    typedef struct packed {
        ccss_rs_t   st;
        logic [2:0] frames;
        logic       request;
    } ccss_rseq_st_t;

    typedef struct packed {
        logic                             fs_m;
        logic                             fs_s;
        logic                             fs_d;
        logic [2:0]                       cv_m;
        logic [2:0]                       cv_s;
        logic [2:0]                       cv_d;
        logic [`CCSS_IDX_LAST:0][15:0]    regs;
        ccss_pwr_t                        pwr;
        logic [25:0]                      tmr;
        logic                             cal_pending;
        logic                             pd_flag;
        logic                             aw_held;
        logic [4:0]                       aw_idx;
        logic                             w_held;
        logic [15:0]                      w_data;
        logic [1:0]                       w_strb;
        logic                             awready;
        logic                             wready;
        logic                             bvalid;
        logic                             arready;
        logic                             rvalid;
        logic [15:0]                      rdata;
        logic [1:0]                       pend;
        logic [1:0]                       valid;
        ccss_clkout_t                     clk_out;
        ccss_conv_t                       conv;
    } ccss_top_st_t;

endpackage

// ---- verilog/ccss_res_seq.sv ----
`timescale 1ns/10ps
`include "ccss_consts.svh"

module ccss_res_seq #(
    parameter int unsigned START_FRAMES = `CCSS_START_FRAMES
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic frame_rise,
    input  wire logic conv_rise,
    output logic      request,
    output logic      running
);

    ccss_pkg::ccss_rseq_st_t st;
    ccss_pkg::ccss_rseq_st_t nxt;

    localparam logic [2:0] LAST_FRAME = 3'(START_FRAMES);

    generate
        if (START_FRAMES < 1 || START_FRAMES > 7) begin : g_bad_frames
            $error("START_FRAMES must be 1 to 7");
        end
    endgenerate

    always_comb begin
        nxt = st;
        case (st.st)
            ccss_pkg::RS_OFF: begin
                if (enable) begin
                    nxt.st     = ccss_pkg::RS_COUNT;
                    nxt.frames = 3'h0;
                end
            end
            ccss_pkg::RS_COUNT: begin
                if (frame_rise) begin
                    nxt.request = 1'b1;
                    nxt.frames  = st.frames + 3'h1;
                    if (st.frames + 3'h1 == LAST_FRAME) begin
                        nxt.st = ccss_pkg::RS_WAIT;
                    end
                end
            end
            ccss_pkg::RS_WAIT: begin
                if (conv_rise) begin
                    nxt.st = ccss_pkg::RS_RUN;
                end
            end
            ccss_pkg::RS_RUN: begin
                nxt.st = ccss_pkg::RS_RUN;
            end
            default: begin
                nxt.st = ccss_pkg::RS_OFF;
            end
        endcase
        if (!enable) begin
            nxt.st      = ccss_pkg::RS_OFF;
            nxt.frames  = 3'h0;
            nxt.request = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= nxt;
        end
    end

    assign request = st.request;
    assign running = (st.st == ccss_pkg::RS_RUN);

    AST_REQ_ON_FRAME: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(st.request) |-> $past(frame_rise) && $past(enable))
        else $error("request rose without a frame edge");

    AST_START_AFTER_FRAMES: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(running) |-> $past(conv_rise) && $past(st.frames) == LAST_FRAME)
        else $error("start not on conversion edge after frame count");

    AST_DISABLE_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!enable && ce) |=> (!st.request && st.st == ccss_pkg::RS_OFF))
        else $error("disabled resource kept request or state");

endmodule

// ---- verilog/ccss_top.sv ----
`timescale 1ns/10ps
`include "ccss_consts.svh"

module ccss_top #(
    parameter int unsigned RAMP_CYC = `CCSS_RAMP_CYC,
    parameter int unsigned CAL_CYC  = `CCSS_CAL_CYC
) (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [6:0]          s_axi_awaddr,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [6:0]          s_axi_araddr,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    input  wire logic                serial_frame_sync,
    input  wire logic [2:0]          conv_clk_pins,
    output ccss_pkg::ccss_clkout_t   clk_out,
    output ccss_pkg::ccss_conv_t     conv,
    output logic                     power_down_state_flag
);

    ccss_pkg::ccss_top_st_t st;
    ccss_pkg::ccss_top_st_t nxt;

    localparam logic [25:0] RAMP_LAST = 26'(RAMP_CYC - 1);
    localparam logic [25:0] CAL_LAST  = 26'(CAL_CYC - 1);

    generate
        if (RAMP_CYC < 1 || RAMP_CYC > 67108864 || CAL_CYC < 1 || CAL_CYC > 67108864)
        begin : g_bad_timer
            $error("timer counts must be 1 to 2**26");
        end
    endgenerate

    logic       frame_rise;
    logic [2:0] cv_rise_all;
    logic [3:0] en_vec;
    logic [3:0] cv_pick;
    logic [3:0] req_vec;
    logic [3:0] run_vec;
    logic [1:0] newp;
    logic       lock;
    logic       go;
    logic       busy;
    logic       wr_ok;
    logic [4:0] rd_idx;
    logic [15:0] status;

    // Only the second and third stages feed edge logic
    assign frame_rise  = st.fs_s & ~st.fs_d;
    assign cv_rise_all = st.cv_s & ~st.cv_d;

    assign en_vec = {st.regs[`CCSS_IDX_ENA][`CCSS_ENA_ADCR],
                     st.regs[`CCSS_IDX_ENA][`CCSS_ENA_ADCL],
                     st.regs[`CCSS_IDX_ENA][`CCSS_ENA_DAC2],
                     st.regs[`CCSS_IDX_ENA][`CCSS_ENA_DAC1]};

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_res
            localparam int LSB = (k == 0) ? `CCSS_SEL_DAC1 : (k == 1) ? `CCSS_SEL_DAC2 :
                                 (k == 2) ? `CCSS_SEL_ADCL : `CCSS_SEL_ADCR;
            logic [1:0] sel;
            assign sel = st.regs[`CCSS_IDX_CLKSEL][LSB +: 2];
            // Code zero falls back to the first clock
            assign cv_pick[k] = (sel == 2'h0) ? cv_rise_all[0] : cv_rise_all[sel - 2'h1];
            ccss_res_seq u_seq (
                .ref_clk    (ref_clk),
                .rstn       (rstn),
                .ce         (ce),
                .enable     (en_vec[k]),
                .frame_rise (frame_rise),
                .conv_rise  (cv_pick[k]),
                .request    (req_vec[k]),
                .running    (run_vec[k])
            );
        end
    endgenerate

    assign newp   = run_vec[3:2] & cv_pick[3:2];
    assign lock   = st.regs[`CCSS_IDX_SER][`CCSS_SER_LOCK] & run_vec[2] & run_vec[3];
    assign go     = &st.pend;
    assign busy   = (|en_vec) | st.regs[`CCSS_IDX_ENA][`CCSS_ENA_DDMIX];
    assign rd_idx = s_axi_araddr[6:2];
    assign status = {1'b1, st.pd_flag, 6'h00, run_vec, st.valid, req_vec[1:0]};

    assign wr_ok = (st.aw_idx != 5'(`CCSS_IDX_STAT)) && (st.aw_idx <= 5'(`CCSS_IDX_LAST))
                && (st.aw_idx != 5'(`CCSS_IDX_ENA) || st.pwr == ccss_pkg::PWR_STBY)
                && (st.aw_idx != 5'(`CCSS_IDX_FILT) || !busy);

    always_comb begin
        nxt      = st;
        nxt.fs_m = serial_frame_sync;
        nxt.fs_s = st.fs_m;
        nxt.fs_d = st.fs_s;
        nxt.cv_m = conv_clk_pins;
        nxt.cv_s = st.cv_m;
        nxt.cv_d = st.cv_s;

        if (s_axi_awvalid && st.awready) begin
            nxt.aw_held = 1'b1;
            nxt.aw_idx  = s_axi_awaddr[6:2];
        end
        if (s_axi_wvalid && st.wready) begin
            nxt.w_held = 1'b1;
            nxt.w_data = s_axi_wdata[15:0];
            nxt.w_strb = s_axi_wstrb[1:0];
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            nxt.aw_held = 1'b0;
            nxt.w_held  = 1'b0;
            nxt.bvalid  = 1'b1;
            // Refused writes still answer OKAY; host checks by readback
            if (wr_ok) begin
                if (st.w_strb[0]) begin
                    nxt.regs[st.aw_idx][7:0] = st.w_data[7:0];
                end
                if (st.w_strb[1]) begin
                    nxt.regs[st.aw_idx][15:8] = st.w_data[15:8];
                end
            end
        end
        if (st.bvalid && s_axi_bready) begin
            nxt.bvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            nxt.rvalid = 1'b1;
            if (rd_idx == 5'(`CCSS_IDX_STAT)) begin
                nxt.rdata = status;
            end else if (rd_idx <= 5'(`CCSS_IDX_LAST)) begin
                nxt.rdata = st.regs[rd_idx];
            end else begin
                nxt.rdata = 16'h0000;
            end
        end else if (st.rvalid && s_axi_rready) begin
            nxt.rvalid = 1'b0;
        end

        case (st.pwr)
            ccss_pkg::PWR_DOWN: begin
                if (!st.regs[`CCSS_IDX_PWR][`CCSS_PWR_PDREQ]) begin
                    nxt.pwr = ccss_pkg::PWR_RAMP;
                    nxt.tmr = 26'h0000000;
                end
            end
            ccss_pkg::PWR_RAMP: begin
                if (st.tmr == RAMP_LAST) begin
                    nxt.tmr = 26'h0000000;
                    if (st.cal_pending || st.regs[`CCSS_IDX_PWR][`CCSS_PWR_AUTOCAL_FORCE_ENABLE]) begin
                        nxt.pwr = ccss_pkg::PWR_CAL;
                    end else begin
                        nxt.pwr = ccss_pkg::PWR_STBY;
                    end
                end else begin
                    nxt.tmr = st.tmr + 26'h0000001;
                end
            end
            ccss_pkg::PWR_CAL: begin
                if (st.tmr == CAL_LAST) begin
                    nxt.pwr         = ccss_pkg::PWR_STBY;
                    nxt.cal_pending = 1'b0;
                end else begin
                    nxt.tmr = st.tmr + 26'h0000001;
                end
            end
            ccss_pkg::PWR_STBY: begin
                nxt.pwr = ccss_pkg::PWR_STBY;
            end
            default: begin
                nxt.pwr = ccss_pkg::PWR_DOWN;
            end
        endcase
        if (st.regs[`CCSS_IDX_PWR][`CCSS_PWR_PDREQ]) begin
            nxt.pwr = ccss_pkg::PWR_DOWN;
        end

        // Defaults win over a write landing in the same cycle
        if (nxt.pwr != ccss_pkg::PWR_STBY) begin
            nxt.regs[`CCSS_IDX_ADCSEL] = `CCSS_CFG_RST;
            nxt.regs[`CCSS_IDX_MIX_A]  = `CCSS_CFG_RST;
            nxt.regs[`CCSS_IDX_MIX_B]  = `CCSS_CFG_RST;
            nxt.regs[`CCSS_IDX_CLKSEL] = `CCSS_CFG_RST;
            nxt.regs[`CCSS_IDX_FILT]   = `CCSS_CFG_RST;
            nxt.regs[`CCSS_IDX_ENA]    = `CCSS_CFG_RST;
        end
        for (int g = `CCSS_IDX_GAIN_LO; g <= `CCSS_IDX_GAIN_HI; g++) begin
            if (!nxt.regs[`CCSS_IDX_ENA][g[0] ? `CCSS_ENA_DAC1 : `CCSS_ENA_DAC2]) begin
                nxt.regs[g] = `CCSS_GAIN_RST;
            end
        end

        // A new sample on the frame edge waits for the next frame
        if (frame_rise) begin
            if (lock) begin
                nxt.valid = {go, go};
                nxt.pend  = go ? newp : (st.pend | newp);
            end else begin
                nxt.valid = st.pend;
                nxt.pend  = newp;
            end
        end else begin
            nxt.pend = st.pend | newp;
        end
        nxt.valid = nxt.valid & run_vec[3:2];
        nxt.pend  = nxt.pend & run_vec[3:2];

        nxt.pd_flag                = (nxt.pwr == ccss_pkg::PWR_STBY);
        nxt.clk_out.clkgen_en      = nxt.regs[`CCSS_IDX_PWR][`CCSS_PWR_CG_LSB +: 3]
                                   & {3{~nxt.regs[`CCSS_IDX_PWR][`CCSS_PWR_PDREQ]}};
        nxt.clk_out.conv_out_en    = {nxt.regs[`CCSS_IDX_PWR][7], nxt.regs[`CCSS_IDX_PWR][5],
                                      nxt.regs[`CCSS_IDX_PWR][3]};
        nxt.clk_out.bit_out_en     = {nxt.regs[`CCSS_IDX_PWR][6], nxt.regs[`CCSS_IDX_PWR][4],
                                      nxt.regs[`CCSS_IDX_PWR][2]};
        nxt.conv.dac_run           = run_vec[1:0];
        nxt.conv.adc_sample        = run_vec[3:2];
        nxt.conv.dac2_mix          = nxt.regs[`CCSS_IDX_ENA][`CCSS_ENA_DDMIX];
        nxt.conv.adc_mix           = nxt.regs[`CCSS_IDX_ENA][`CCSS_ENA_AAMIX];
        nxt.awready                = !nxt.aw_held && !nxt.bvalid;
        nxt.wready                 = !nxt.w_held && !nxt.bvalid;
        nxt.arready                = !nxt.rvalid;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st                       <= '0;
            st.regs[`CCSS_IDX_PWR]   <= `CCSS_PWR_RST;
            st.cal_pending           <= 1'b1;
            for (int g = `CCSS_IDX_GAIN_LO; g <= `CCSS_IDX_GAIN_HI; g++) begin
                st.regs[g] <= `CCSS_GAIN_RST;
            end
        end else if (ce) begin
            st <= nxt;
        end
    end

    assign s_axi_awready         = st.awready;
    assign s_axi_wready          = st.wready;
    assign s_axi_bvalid          = st.bvalid;
    assign s_axi_bresp           = 2'h0;
    assign s_axi_arready         = st.arready;
    assign s_axi_rvalid          = st.rvalid;
    assign s_axi_rdata           = {16'h0000, st.rdata};
    assign s_axi_rresp           = 2'h0;
    assign clk_out               = st.clk_out;
    assign conv                  = st.conv;
    assign power_down_state_flag = st.pd_flag;

    AST_ENA_REJECT: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st.pwr != ccss_pkg::PWR_STBY) |-> st.regs[`CCSS_IDX_ENA] == 16'h0000)
        else $error("enable register set outside standby");

    AST_READBACK: assert property (@(posedge ref_clk) disable iff (!rstn)
        ($rose(st.bvalid) && st.w_strb == 2'h3
         && st.aw_idx inside {[`CCSS_IDX_CG_LO:`CCSS_IDX_CG_HI]})
        |-> st.regs[st.aw_idx] == st.w_data)
        else $error("clock generator write not stored");

    AST_RAMP_TIME: assert property (@(posedge ref_clk) disable iff (!rstn)
        ($past(st.pwr) == ccss_pkg::PWR_RAMP && st.pwr != ccss_pkg::PWR_RAMP
         && st.pwr != ccss_pkg::PWR_DOWN) |-> $past(st.tmr) == RAMP_LAST)
        else $error("ramp left early or late");

    AST_CAL_TIME: assert property (@(posedge ref_clk) disable iff (!rstn)
        ($past(st.pwr) == ccss_pkg::PWR_CAL && st.pwr == ccss_pkg::PWR_STBY)
        |-> $past(st.tmr) == CAL_LAST && !st.cal_pending)
        else $error("calibration length wrong");

    AST_PD_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
        st.pd_flag == (st.pwr == ccss_pkg::PWR_STBY))
        else $error("power down status flag mismatch");

    AST_CFG_DEFAULT: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st.pwr == ccss_pkg::PWR_DOWN) |-> (st.regs[`CCSS_IDX_CLKSEL] == 16'h0000
         && st.regs[`CCSS_IDX_FILT] == 16'h0000 && st.regs[`CCSS_IDX_MIX_A] == 16'h0000))
        else $error("config not at default in power down");

    AST_GAIN_ATTEN: assert property (@(posedge ref_clk) disable iff (!rstn)
        !st.regs[`CCSS_IDX_ENA][`CCSS_ENA_DAC1] |-> st.regs[9] == `CCSS_GAIN_RST)
        else $error("gain not at full attenuation");

    AST_FILT_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ce && busy) ##1 busy |-> $stable(st.regs[`CCSS_IDX_FILT]))
        else $error("filter mode changed while enabled");

    AST_MIX_NOW: assert property (@(posedge ref_clk) disable iff (!rstn)
        st.conv.dac2_mix == st.regs[`CCSS_IDX_ENA][`CCSS_ENA_DDMIX])
        else $error("mix enable not applied at once");

    AST_LOCK_PAIR: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ce && frame_rise && lock) |=> st.valid[0] == st.valid[1])
        else $error("locked ADCs reported in different frames");

endmodule

// ---- dv/ccss_host_link.sv ----
`timescale 1ns/10ps
module ccss_host_link (
    output logic       frame_sync,
    output logic [2:0] conv_clks
);
    logic       lclk = 1'b0;
    logic [2:0] cnt  = 3'h0;
    always #40 lclk = ~lclk;
    always @(posedge lclk) cnt <= cnt + 3'h1;
    // One sync pulse per eight link cycles, far slower than the conversion clocks
    assign frame_sync = (cnt == 3'h0);
    assign conv_clks  = {lclk, cnt[0], lclk};
endmodule

// ---- dv/ccss_top_bench.sv ----
`timescale 1ns/10ps
module ccss_top_bench;
    logic                   ref_clk = 1'b0;
    logic                   rstn = 1'b0;
    logic                   awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic                   ce = 1'b1, brd = 1'b0, rrd = 1'b0;
    logic [3:0]             wsb = 4'hF;
    logic [6:0]             awa = 7'h00, ara = 7'h00;
    logic [31:0]            wdt = 32'h0, lf, rdt, exq[$];
    logic                   awr, wr_r, bv, arr, rv, pdf, fs;
    logic [1:0]             br, rr;
    logic [2:0]             cp;
    ccss_pkg::ccss_clkout_t co;
    ccss_pkg::ccss_conv_t   cv;
    int                     errors = 0, samples_checked = 0, frames = 0, f0, n;
    int                     cyc = 0, t0;
    localparam int          RAMP = 50, CAL = 20;
    ccss_top #(.RAMP_CYC(RAMP), .CAL_CYC(CAL)) uut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_wdata(wdt), .s_axi_wstrb(wsb), .s_axi_bvalid(bv),
        .s_axi_bready(brd), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdt),
        .s_axi_rresp(rr), .serial_frame_sync(fs), .conv_clk_pins(cp), .clk_out(co),
        .conv(cv), .power_down_state_flag(pdf));
    ccss_host_link host (.frame_sync(fs), .conv_clks(cp));
    always #5 ref_clk = ~ref_clk;
    always @(posedge fs) frames++;
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic timeout;
        errors++;
        test_done();
    endtask
    // Read data is judged by the monitor against the oldest note
    always @(posedge ref_clk) if (rv === 1'b1 && exq.size() > 0)
        chk("rdata", exq.pop_front(), rdt);
    always @(posedge ref_clk) if (bv === 1'b1 || rv === 1'b1)
        chk("resp", 4'h0, {br, rr});
    task automatic wr(input logic [4:0] i, input logic [15:0] d);
        int k;
        k = 0;
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= {i, 2'h0};
        wdt <= {16'h0000, d};
        do begin
            @(posedge ref_clk);
            k++;
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (bv !== 1'b1 && k < 100);
        if (k >= 100) timeout();
    endtask
    task automatic rd(input logic [4:0] i, input logic [15:0] e);
        int k;
        k = 0;
        arv <= 1'b1;
        ara <= {i, 2'h0};
        exq.push_back({16'h0000, e});
        do begin
            @(posedge ref_clk);
            k++;
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1 && k < 100);
        if (k >= 100) timeout();
    endtask
    task automatic wfr(input int k);
        for (n = 0; n < 2000 && frames - f0 < k; n++) @(posedge ref_clk);
        if (n >= 2000) timeout();
    endtask
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        brd <= 1'b1;
        rrd <= 1'b1;
        rd(28, 16'h8000);
        rd(5, 16'h8080);
        wr(27, 16'h0101);
        rd(27, 16'h0000);
        wr(28, 16'h3894);
        t0 = cyc;
        // Frozen cycles stretch the power-up by exactly their number
        ce <= 1'b0;
        repeat (10) @(posedge ref_clk);
        ce <= 1'b1;
        rd(28, 16'h3894);
        chk("clk_out", {3'h7, 3'h4, 3'h3}, co);
        lf = nx(32'h0F263C31);
        wr(16, lf[15:0]);
        rd(16, lf[15:0]);
        wsb <= 4'h1;
        wr(17, 16'hABCD);
        rd(17, 16'h00CD);
        wsb <= 4'hF;
        lf = nx(lf) | 32'h0010;
        wr(26, lf[15:0]);
        rd(26, lf[15:0]);
        for (n = 0; n < 200 && pdf !== 1'b1; n++) @(posedge ref_clk);
        if (n >= 200) timeout();
        // Ten frozen cycles plus one to leave power down into ramp
        chk("ramp", 32'(RAMP + CAL + 11), cyc - t0);
        rd(0, 16'hC000);
        wr(15, 16'h0100);
        rd(15, 16'h0100);
        wr(25, 16'h0003);
        rd(25, 16'h0003);
        f0 = frames;
        wfr(1);
        // Start clear of a sync edge so the bench and the block count alike
        repeat (12) @(posedge ref_clk);
        f0 = frames;
        wr(27, 16'h1113);
        repeat (2) @(posedge ref_clk);
        chk("mix", 2'h3, {cv.dac2_mix, cv.adc_mix});
        wfr(2);
        rd(0, 16'hC001);
        for (n = 0; n < 1000 && cv.dac_run[0] !== 1'b1; n++) @(posedge ref_clk);
        if (n >= 1000) timeout();
        chk("start", 6, frames - f0);
        chk("adc", 2'h3, cv.adc_sample);
        wr(3, 16'h1234);
        rd(3, 16'h1234);
        wr(4, 16'h1234);
        rd(4, 16'h8080);
        wr(25, 16'h0000);
        rd(25, 16'h0003);
        f0 = frames;
        wfr(2);
        rd(0, 16'hC0DD);
        wr(27, 16'h0000);
        rd(3, 16'h8080);
        rd(0, 16'hC000);
        wr(28, 16'h8000);
        rd(25, 16'h0000);
        rd(15, 16'h0000);
        chk("pdflag", 1'b0, pdf);
        $display("startup sequence test ended");
        test_done();
    end
endmodule
